// file: shared/fsp_pkg.sv
// Constants, pin bundle and state codes for the ferroelectric memory serial port.
// Assumes one system clock; all pins arrive asynchronous to it.
package fsp_pkg;
    // ==========================================================
    // Array geometry
    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;
    localparam int DATA_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // ==========================================================
    // Op-codes
    localparam logic [7:0] OP_SET_WEL = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OP_CLR_WEL = 8'h04; // clear_write_latch_cmd
    localparam logic [7:0] OP_RD_STAT = 8'h05; // read_status_cmd
    localparam logic [7:0] OP_WR_STAT = 8'h01; // write_status_cmd
    localparam logic [7:0] OP_RD_MEM = 8'h03;
    localparam logic [7:0] OP_WR_MEM = 8'h02;
    localparam logic [7:0] OP_RD_IDENT = 8'h9f; // read_ident_cmd
    localparam logic [7:0] OP_SLEEP = 8'hb9;

    // ==========================================================
    // Status layout and reset values
    localparam int STAT_PROT_BIT = 7;  // status_write_protect_enable
    localparam int STAT_KEEP_LO = 2;   // Bits 7..2 are writable
    localparam logic [5:0] STAT_RST = 6'h00;

    // ==========================================================
    // Pin bundle as seen by the device
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
        logic pause_n;
        logic wp_n;
    } fsp_pins_s;
    localparam fsp_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0, pause_n: 1'b1, wp_n: 1'b1};

    // ==========================================================
    // Command decoder states, one-hot
    typedef enum logic [6:0] {
        ST_OP = 7'h01,
        ST_ADDR = 7'h02,
        ST_RDATA = 7'h04,
        ST_WDATA = 7'h08,
        ST_RSTAT = 7'h10,
        ST_WSTAT = 7'h20,
        ST_IGN = 7'h40
    } fsp_state_e;
endpackage

// file: hw/fsp_slave.sv
// Serial slave front end with its 32K x 8 array and status register.
// Assumes clk much faster than the serial clock; all pins are synchronised here.
// Behaviour
// - Deselected: standby, output tristated
// - Deselected: all input activity ignored
// - Pause low: output tristated, clock ignored
// - Pause freezes transfer, resumes same point
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Output carries only read data
// - Works in clock modes 0 and 3
// - Status write gated by protect pin/bit
// - Array holds 32768 bytes
// - Array writes need no wait
// - Eight-bit op-codes decoded
// - Partial op-code discarded on deselect
// - Sixteen-bit address, top bit ignored
module fsp_slave
    import fsp_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire fsp_pins_s pins,
    output logic miso,
    output logic miso_oe
);
    // ==========================================================
    // Pin synchronisers
    fsp_pins_s sync1;
    fsp_pins_s sync2;
    logic sck_d;
    logic cs_d;

    // Two flops on every pin, then one more on sck and cs_n for edge finding
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= PINS_IDLE;
            sync2 <= PINS_IDLE;
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sck_d <= sync2.sck;
            cs_d <= sync2.cs_n;
        end
    end

    // ==========================================================
    // Edge events
    logic active;
    logic rise_act;
    logic fall_act;
    logic cs_rise;
    // Edges count only while selected and not paused
    assign active = !sync2.cs_n && sync2.pause_n;
    assign rise_act = active && sync2.sck && !sck_d;
    assign fall_act = active && !sync2.sck && sck_d;
    assign cs_rise = sync2.cs_n && !cs_d;

    // ==========================================================
    // Receive path and decoder
    fsp_state_e state;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic byte_done;
    logic addr_hi_done;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [5:0] stat_hi;
    logic wel;
    logic wel_drop;
    logic stat_locked;
    logic stat_we;
    logic mem_we;
    logic [7:0] status;
    logic rx_op_write;

    assign next_rx = {rx[6:0], sync2.mosi};
    assign byte_done = rise_act && (bit_cnt == BIT_LAST);
    assign status = {stat_hi, wel, 1'b0};
    assign stat_locked = stat_hi[STAT_PROT_BIT-STAT_KEEP_LO] && !sync2.wp_n;
    assign stat_we = byte_done && (state == ST_WSTAT) && wel && !stat_locked;
    assign mem_we = byte_done && (state == ST_WDATA) && wel;

    // Bit counter and shift register; deselect restarts the byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt <= BIT_FIRST;
            rx <= 8'h00;
        end else if (sync2.cs_n) begin
            bit_cnt <= BIT_FIRST;
        end else if (rise_act) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx <= next_rx;
        end
    end

    // Command state machine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_OP;
            addr_hi_done <= 1'b0;
        end else if (sync2.cs_n) begin
            state <= ST_OP;
            addr_hi_done <= 1'b0;
        end else if (byte_done) begin
            unique case (state)
                ST_OP: begin
                    unique case (next_rx)
                        OP_RD_STAT: state <= ST_RSTAT;
                        OP_WR_STAT: state <= ST_WSTAT;
                        OP_RD_MEM, OP_WR_MEM: state <= ST_ADDR;
                        default: state <= ST_IGN; // Latch ops, sleep, ident, unknown
                    endcase
                end
                ST_ADDR: begin
                    addr_hi_done <= 1'b1;
                    if (addr_hi_done) begin
                        state <= (rx_op_write) ? ST_WDATA : ST_RDATA;
                    end
                end
                ST_WSTAT: state <= ST_IGN;
                ST_RDATA, ST_WDATA, ST_RSTAT, ST_IGN: state <= state;
            endcase
        end
    end

    // Remember whether the array command was a write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_op_write <= 1'b0;
        end else if (byte_done && state == ST_OP) begin
            rx_op_write <= (next_rx == OP_WR_MEM);
        end
    end

    // ==========================================================
    // Address counter: 16 bits received, top bit dropped, wraps
    logic [2:0] tx_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr <= '0;
        end else if (byte_done && state == ST_ADDR) begin
            if (!addr_hi_done) begin
                addr[ADDR_W-1:8] <= next_rx[ADDR_W-9:0];
            end else begin
                addr[7:0] <= next_rx;
            end
        end else if (mem_we || (byte_done && state == ST_WDATA)) begin
            addr <= addr + 1'b1;
        end else if (fall_act && state == ST_RDATA && tx_cnt == BIT_LAST) begin
            addr <= addr + 1'b1;
        end
    end

    // Array write completes in the same cycle as the last bit
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[addr] <= next_rx;
        end
    end

    // ==========================================================
    // Status register and write latch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_hi <= STAT_RST;
        end else if (stat_we) begin
            stat_hi <= next_rx[7:STAT_KEEP_LO];
        end
    end

    // Latch set/clear, dropped at deselect after status or array write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wel <= 1'b0;
            wel_drop <= 1'b0;
        end else if (cs_rise) begin
            if (wel_drop) begin
                wel <= 1'b0;
            end
            wel_drop <= 1'b0;
        end else if (byte_done && state == ST_OP) begin
            if (next_rx == OP_SET_WEL) begin
                wel <= 1'b1;
            end else if (next_rx == OP_CLR_WEL) begin
                wel <= 1'b0;
            end
            wel_drop <= (next_rx == OP_WR_STAT) || (next_rx == OP_WR_MEM);
        end
    end

    // ==========================================================
    // Transmit path
    logic [7:0] tx;
    logic [ADDR_W-1:0] addr_next;
    assign addr_next = addr + 1'b1;

    // Load on entering a read, shift on each falling edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx <= 8'h00;
            tx_cnt <= BIT_FIRST;
            miso <= 1'b0;
        end else if (sync2.cs_n) begin
            tx_cnt <= BIT_FIRST;
        end else if (byte_done && state == ST_OP && next_rx == OP_RD_STAT) begin
            tx <= status;
            tx_cnt <= BIT_FIRST;
        end else if (byte_done && state == ST_ADDR && addr_hi_done && !rx_op_write) begin
            tx <= mem[{addr[ADDR_W-1:8], next_rx}];
            tx_cnt <= BIT_FIRST;
        end else if (fall_act && (state == ST_RDATA || state == ST_RSTAT)) begin
            miso <= tx[7];
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == BIT_LAST) begin
                tx <= (state == ST_RSTAT) ? status : mem[addr_next];
            end else begin
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // Drive only in read phases while selected and not paused
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= active && (state == ST_RDATA || state == ST_RSTAT);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    deselect_tristate_a: assert property (sync2.cs_n |=> !miso_oe) else $error("output driven while deselected");
    deselect_idle_a: assert property (sync2.cs_n |=> state == ST_OP && bit_cnt == BIT_FIRST)
        else $error("decoder not idle while deselected");
    pause_tristate_a: assert property (!sync2.pause_n |=> !miso_oe) else $error("output driven while paused");
    pause_freeze_a: assert property (!sync2.cs_n && !sync2.pause_n |=> $stable(bit_cnt) && $stable(state) && $stable(tx))
        else $error("transfer moved while paused");
    rise_count_a: assert property (rise_act && !sync2.cs_n |=> bit_cnt == $past(bit_cnt) + 3'h1)
        else $error("bit not taken on rising edge");
    fall_only_a: assert property (!fall_act |=> $stable(miso)) else $error("output changed off falling edge");
    drive_reads_a: assert property (miso_oe |-> $past(state) == ST_RDATA || $past(state) == ST_RSTAT)
        else $error("output driven outside a read");
    status_lock_a: assert property (byte_done && state == ST_WSTAT && stat_locked |=> $stable(stat_hi))
        else $error("protected status written");
    partial_op_a: assert property (cs_rise && $past(state) == ST_OP |-> $stable(wel))
        else $error("partial op-code acted");
    write_nowait_a: assert property (mem_we |=> addr == $past(addr) + 1'b1 && state == ST_WDATA)
        else $error("array write stalled");

    read_seen_c: cover property (state == ST_RDATA && fall_act);
    write_seen_c: cover property (mem_we);
    status_read_c: cover property (state == ST_RSTAT && miso_oe);
    pause_read_c: cover property (state == ST_RDATA && !sync2.pause_n ##1 sync2.pause_n);
endmodule // fsp_slave

// file: verification/fsp_host.sv
// Host serial master model driving the pin bundle of the memory port.
// Assumes the bench calls its tasks; pins change only at falling clk edges.
module fsp_host
    import fsp_pkg::*;
(
    input wire logic clk,
    input wire logic miso,
    input wire logic miso_oe,
    output fsp_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;
    logic oe_mid;
    logic so_line;

    // Released output reads as the inverse of its last value
    assign so_line = miso_oe ? miso : ~miso;

    // ==========================================================
    // Framing
    // Pins idle and deselected from time zero
    initial pins = PINS_IDLE;

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Select with the serial clock parked at the mode idle level
    task automatic start(input logic mode3);
        cpol = mode3;
        pins.sck = mode3;
        wait_clk(4);
        pins.cs_n = 1'b0;
        wait_clk(4);
    endtask

    // Shift nb bits out and in, MSB first, 160 ns per bit
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i >= 8 - nb; i--) begin
            pins.sck = 1'b0;
            pins.mosi = tx[i];
            wait_clk(4);
            pins.sck = 1'b1;
            rx[i] = so_line;
            wait_clk(4);
        end
    endtask

    // Park the clock, disturb the data line, then deselect
    task automatic stop();
        pins.sck = cpol;
        pins.mosi = ~pins.mosi;
        wait_clk(4);
        pins.cs_n = 1'b1;
        wait_clk(8);
    endtask

    // Pause with the clock low, wiggle clock and data, then resume
    task automatic hold_burst();
        pins.sck = 1'b0;
        wait_clk(4);
        pins.pause_n = 1'b0;
        wait_clk(4);
        repeat (2) begin
            pins.sck = ~pins.sck;
            pins.mosi = ~pins.mosi;
            wait_clk(4);
        end
        oe_mid = miso_oe;
        pins.pause_n = 1'b1;
        wait_clk(4);
    endtask

    // Set the write-protect pin level between frames
    task automatic protect(input logic lvl);
        pins.wp_n = lvl;
        wait_clk(1);
    endtask
endmodule // fsp_host

// file: verification/tb_top.sv
// Self-checking bench for the serial memory port, host model on the pins.
// Assumes the design's package is compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic miso;
    logic miso_oe;
    fsp_pins_s pins;
    int mismatches = 0;
    int comparisons = 0;
    logic [7:0] rx;

`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

    // ==========================================================
    // Structure
    fsp_slave u_dut (.clk(clk), .arst_n(arst_n), .pins(pins), .miso(miso), .miso_oe(miso_oe));
    fsp_host u_host (.clk(clk), .miso(miso), .miso_oe(miso_oe), .pins(pins));

    // Clock of 20 ns
    initial forever #10 clk = ~clk;

    // ==========================================================
    // Helpers
    task automatic op(input logic [7:0] c, input logic [7:0] d, input int n);
        u_host.start(1'b0);
        u_host.xfer(c, 8, rx);
        if (n > 0) u_host.xfer(d, 8, rx);
        u_host.stop();
    endtask

    task automatic stat_is(input logic [7:0] exp);
        u_host.start(1'b0);
        u_host.xfer(OP_RD_STAT, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        u_host.stop();
        `CHK("status", exp, rx)
    endtask

    // Write two bytes from an address in the chosen mode
    task automatic wr2(input logic mode3, input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
        u_host.start(mode3);
        u_host.xfer(OP_WR_MEM, 8, rx);
        u_host.xfer(a[15:8], 8, rx);
        u_host.xfer(a[7:0], 8, rx);
        u_host.xfer(d0, 8, rx);
        u_host.xfer(d1, 8, rx);
        u_host.stop();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_ignored();
        u_host.xfer(OP_SET_WEL, 8, rx);
        `CHK("oe_desel", 1'b0, miso_oe)
        stat_is(8'h00);
        // Ident and sleep codes answer nothing on the output
        u_host.start(1'b1);
        u_host.xfer(OP_RD_IDENT, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        `CHK("oe_ident", 1'b0, miso_oe)
        u_host.stop();
        op(OP_SLEEP, 8'h00, 0);
        u_host.start(1'b0);
        u_host.xfer(OP_SET_WEL, 4, rx);
        u_host.stop();
        stat_is(8'h00);
    endtask

    task automatic t_status();
        op(OP_SET_WEL, 8'h00, 0);
        stat_is(8'h02);
        op(OP_CLR_WEL, 8'h00, 0);
        stat_is(8'h00);
        op(OP_SET_WEL, 8'h00, 0);
        op(OP_WR_STAT, 8'hfe, 1);
        stat_is(8'hfc);
        u_host.protect(1'b0);
        op(OP_SET_WEL, 8'h00, 0);
        op(OP_WR_STAT, 8'h00, 1);
        stat_is(8'hfc);
        u_host.protect(1'b1);
        op(OP_SET_WEL, 8'h00, 0);
        op(OP_WR_STAT, 8'h00, 1);
        stat_is(8'h00);
    endtask

    // Mode 3 write across the top of the array, mode 0 read with a pause
    task automatic t_memory();
        op(OP_SET_WEL, 8'h00, 0);
        wr2(1'b1, 16'hffff, 8'h11, 8'h22);
        wr2(1'b0, 16'h7fff, 8'h55, 8'h66);
        u_host.start(1'b0);
        u_host.xfer(OP_RD_MEM, 8, rx);
        u_host.xfer(8'h7f, 8, rx);
        u_host.xfer(8'hff, 8, rx);
        u_host.xfer(8'h00, 8, rx);
        `CHK("rd_first", 8'h11, rx)
        `CHK("oe_read", 1'b1, miso_oe)
        u_host.hold_burst();
        `CHK("oe_pause", 1'b0, u_host.oe_mid)
        u_host.xfer(8'h00, 8, rx);
        `CHK("rd_wrap", 8'h22, rx)
        u_host.stop();
        `CHK("oe_end", 1'b0, miso_oe)
    endtask

    // ==========================================================
    // Verdict
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence after a 20 cycle reset
    initial begin
        repeat (20) @(negedge clk);
        `CHK("oe_reset", 1'b0, miso_oe)
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_ignored();
        t_status();
        t_memory();
        close_out();
    end

    // Watchdog well beyond the expected run
    initial begin
        #1ms;
        mismatches++;
        close_out();
    end
endmodule // tb_top
